// ---- verilog/spc_pkg.sv ----
// Purpose: Shared constants and types of the protocol snoop classifier.
// Assumes: 32-bit AXI4-Lite register bus, byte addressing.
// Notes: All offsets, bit positions, reset values and protocol codes live here.
`default_nettype none

package spc_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam int SPC_AW = 8;
  localparam logic [7:0] SPC_OFS_CTRL = 8'h50;
  localparam logic [7:0] SPC_OFS_STAT = 8'h54;
  localparam logic [31:0] SPC_CTRL_RST = 32'h0000_0000;
  // Bits 31:19 and 7:6 are not stored and read back as zero.
  localparam logic [31:0] SPC_CTRL_MASK = 32'h0007_FF3F;
  localparam logic [1:0] SPC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SPC_RESP_SLVERR = 2'h2;

  // ********************************************************************
  // Control and status word fields
  // ********************************************************************
  localparam int BIT_ADDR_RES = 0;
  localparam int BIT_REV_ADDR_RES = 1;
  localparam int BIT_DHCP = 2;
  localparam int BIT_ICMP4 = 3;
  localparam int BIT_ICMP6_ON = 4;
  localparam int BIT_ICMP6_TRAP = 5;
  localparam int BIT_IGMP_DIP = 8;
  localparam int BIT_JL_ON = 9;
  localparam int BIT_JL_TRAP = 10;
  localparam int BIT_IGQ_ON = 11;
  localparam int BIT_IGQ_TRAP = 12;
  localparam int BIT_IGU_ON = 13;
  localparam int BIT_IGU_TRAP = 14;
  localparam int BIT_LR_ON = 15;
  localparam int BIT_LR_TRAP = 16;
  localparam int BIT_LQ_ON = 17;
  localparam int BIT_LQ_TRAP = 18;
  localparam int STAT_CLASS_LSB = 0;
  localparam int STAT_COPY = 4;
  localparam int STAT_ONLY = 5;

  // ********************************************************************
  // Protocol codes
  // ********************************************************************
  localparam logic [15:0] ETH_ADDR_RES = 16'h0806;
  localparam logic [15:0] ETH_REV_ADDR_RES = 16'h8035;
  localparam logic [15:0] ETH_IPV4 = 16'h0800;
  localparam logic [15:0] ETH_IPV6 = 16'h86DD;
  localparam logic [7:0] PROTO_ICMP4 = 8'h01;
  localparam logic [7:0] PROTO_IGMP = 8'h02;
  localparam logic [7:0] PROTO_UDP = 8'h11;
  localparam logic [7:0] NEXT_ICMP6 = 8'h3A;
  localparam logic [15:0] PORT_DHCP_SRV = 16'h0043;
  localparam logic [15:0] PORT_DHCP_CLI = 16'h0044;
  localparam logic [3:0] CLASS_D_TOP = 4'hE;
  localparam logic [7:0] IGMP_QUERY = 8'h11;
  localparam logic [7:0] IGMP_REP_V1 = 8'h12;
  localparam logic [7:0] IGMP_REP_V2 = 8'h16;
  localparam logic [7:0] IGMP_LEAVE = 8'h17;
  localparam logic [7:0] IGMP_REP_V3 = 8'h22;
  localparam logic [7:0] LSN_QUERY = 8'h82;
  localparam logic [7:0] LSN_REP_V1 = 8'h83;
  localparam logic [7:0] LSN_DONE = 8'h84;
  localparam logic [7:0] LSN_REP_V2 = 8'h8F;

  typedef enum logic [3:0] {
    CLS_NONE = 4'h0,
    CLS_ADDR_RES = 4'h1,
    CLS_REV_ADDR_RES = 4'h2,
    CLS_DHCP = 4'h3,
    CLS_ICMP4 = 4'h4,
    CLS_ICMP6 = 4'h5,
    CLS_IGMP_JL = 4'h6,
    CLS_IGMP_QRY = 4'h7,
    CLS_IGMP_UKN = 4'h8,
    CLS_LSN_QRY = 4'h9,
    CLS_LSN_REP = 4'hA
  } spc_class_e;

endpackage

`default_nettype wire

// ---- verilog/spc_cls_if.sv ----
// Purpose: Carrier between the register side and the classifier.
// Assumes: One clock domain.
// Notes: Header fields arrive already parsed by the forwarding engine.
`timescale 1ns/1ns
`default_nettype none

interface spc_cls_if;
  import spc_pkg::*;
  logic [31:0] ctrl;
  logic hdr_valid;
  logic [15:0] eth_type;
  logic [7:0] ip_proto;
  logic [31:0] ip_dst;
  logic [7:0] ip6_next;
  logic [7:0] msg_type;
  logic [15:0] udp_dport;
  logic res_valid;
  spc_class_e res_class;
  logic res_copy;
  logic res_only;
  logic res_l2;
  modport ctl (output ctrl, hdr_valid, eth_type, ip_proto, ip_dst, ip6_next, msg_type,
               udp_dport, input res_valid, res_class, res_copy, res_only, res_l2);
  modport cls (input ctrl, hdr_valid, eth_type, ip_proto, ip_dst, ip6_next, msg_type,
               udp_dport, output res_valid, res_class, res_copy, res_only, res_l2);
endinterface

`default_nettype wire

// ---- verilog/spc_classifier.sv ----
// Purpose: Classify one parsed header and decide CPU copy, trap and layer-2 forwarding.
// Assumes: Header fields are stable in the cycle hdr_valid is high.
// Notes: Decision appears one cycle after hdr_valid.
`timescale 1ns/1ns
`default_nettype none

module spc_classifier
  import spc_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  spc_cls_if.cls ifc
);

  // ********************************************************************
  // Header decode
  // ********************************************************************
  logic is_ip4;
  logic is_ip6_icmp;
  logic igmp_hit;
  logic igmp_dest_ip_check_on;
  spc_class_e cls;
  logic [1:0] sel;

  assign igmp_dest_ip_check_on = ifc.ctrl[BIT_IGMP_DIP];
  assign is_ip4 = (ifc.eth_type == ETH_IPV4);
  assign is_ip6_icmp = (ifc.eth_type == ETH_IPV6) && (ifc.ip6_next == NEXT_ICMP6);
  assign igmp_hit = is_ip4 && (ifc.ip_proto == PROTO_IGMP) &&
                    (!igmp_dest_ip_check_on || (ifc.ip_dst[31:28] == CLASS_D_TOP));

  // Returns {snoop on, trap select}; the mode bit only counts while snooping is on.
  function automatic logic [1:0] class_sel(input spc_class_e c, input logic [31:0] w);
    logic [1:0] s;
    s = 2'h0;
    case (c)
      CLS_ADDR_RES: s = {w[BIT_ADDR_RES], 1'b0};
      CLS_REV_ADDR_RES: s = {w[BIT_REV_ADDR_RES], 1'b0};
      CLS_DHCP: s = {w[BIT_DHCP], 1'b0};
      CLS_ICMP4: s = {w[BIT_ICMP4], 1'b0};
      CLS_ICMP6: s = {w[BIT_ICMP6_ON], w[BIT_ICMP6_TRAP]};
      CLS_IGMP_JL: s = {w[BIT_JL_ON], w[BIT_JL_TRAP]};
      CLS_IGMP_QRY: s = {w[BIT_IGQ_ON], w[BIT_IGQ_TRAP]};
      CLS_IGMP_UKN: s = {w[BIT_IGU_ON], w[BIT_IGU_TRAP]};
      CLS_LSN_QRY: s = {w[BIT_LQ_ON], w[BIT_LQ_TRAP]};
      CLS_LSN_REP: s = {w[BIT_LR_ON], w[BIT_LR_TRAP]};
      default: s = 2'h0;
    endcase
    return s;
  endfunction

  always_comb begin
    cls = CLS_NONE;
    if (ifc.eth_type == ETH_ADDR_RES) begin
      cls = CLS_ADDR_RES;
    end else if (ifc.eth_type == ETH_REV_ADDR_RES) begin
      cls = CLS_REV_ADDR_RES;
    end else if (igmp_hit) begin
      case (ifc.msg_type)
        IGMP_QUERY: cls = CLS_IGMP_QRY;
        IGMP_REP_V1, IGMP_REP_V2, IGMP_REP_V3, IGMP_LEAVE: cls = CLS_IGMP_JL;
        default: cls = CLS_IGMP_UKN;
      endcase
    end else if (is_ip4 && ifc.ip_proto == PROTO_ICMP4) begin
      cls = CLS_ICMP4;
    end else if (is_ip4 && ifc.ip_proto == PROTO_UDP &&
                 (ifc.udp_dport == PORT_DHCP_SRV || ifc.udp_dport == PORT_DHCP_CLI)) begin
      cls = CLS_DHCP;
    end else if (is_ip6_icmp) begin
      // Listener messages are kept out of the general ICMPv6 class.
      case (ifc.msg_type)
        LSN_QUERY: cls = CLS_LSN_QRY;
        LSN_REP_V1, LSN_DONE, LSN_REP_V2: cls = CLS_LSN_REP;
        default: cls = CLS_ICMP6;
      endcase
    end
  end

  assign sel = class_sel(cls, ifc.ctrl);

  // ********************************************************************
  // Registered decision
  // ********************************************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ifc.res_valid <= 1'b0;
      ifc.res_class <= CLS_NONE;
      ifc.res_copy <= 1'b0;
      ifc.res_only <= 1'b0;
      ifc.res_l2 <= 1'b0;
    end else begin
      ifc.res_valid <= ifc.hdr_valid;
      ifc.res_class <= ifc.hdr_valid ? cls : CLS_NONE;
      ifc.res_copy <= ifc.hdr_valid && sel[1] && !sel[0];
      ifc.res_only <= ifc.hdr_valid && sel[1] && sel[0];
      ifc.res_l2 <= ifc.hdr_valid && !(sel[1] && sel[0]);
    end
  end

  a_dip_reject: assert property (@(posedge clock) disable iff (!nrst)
    (ifc.hdr_valid && is_ip4 && ifc.ip_proto == PROTO_IGMP && ifc.ctrl[BIT_IGMP_DIP] &&
     ifc.ip_dst[31:28] != CLASS_D_TOP)
    |=> (ifc.res_class != CLS_IGMP_JL && ifc.res_class != CLS_IGMP_QRY &&
         ifc.res_class != CLS_IGMP_UKN))
    else $error("IGMP class given to a non multicast destination");

  a_icmp6_class: assert property (@(posedge clock) disable iff (!nrst)
    (ifc.hdr_valid && ifc.eth_type == ETH_IPV6 && ifc.ip6_next == NEXT_ICMP6 &&
     ifc.msg_type == 8'h80)
    |=> (ifc.res_class == CLS_ICMP6))
    else $error("ICMPv6 echo not classified as ICMPv6");

endmodule // spc_classifier

`default_nettype wire

// ---- verilog/spc_top.sv ----
// Purpose: Protocol snoop classifier with its AXI4-Lite control register.
// Assumes: Header fields come from logic on the same clock.
// Notes: Write answers one edge after both halves are taken, reads on the edge the address is taken.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

module spc_top
  import spc_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [SPC_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [SPC_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic hdr_valid,
  input wire logic [15:0] hdr_eth_type,
  input wire logic [7:0] hdr_ip_proto,
  input wire logic [31:0] hdr_ip_dst,
  input wire logic [7:0] hdr_ip6_next,
  input wire logic [7:0] hdr_msg_type,
  input wire logic [15:0] hdr_udp_dport,
  output logic dec_valid,
  output logic [3:0] dec_class,
  output logic dec_cpu_copy,
  output logic dec_cpu_only,
  output logic dec_l2_fwd
);

  // ********************************************************************
  // Write channel
  // ********************************************************************
  logic aw_got_r;
  logic w_got_r;
  logic [SPC_AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic do_wr;
  logic [5:0] stat_r;

  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready = !w_got_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign do_wr = aw_got_r && w_got_r && !bvalid_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      aw_got_r <= 1'b0;
      awaddr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_got_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      w_got_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (do_wr) begin
      w_got_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bvalid_r <= 1'b0;
      bresp_r <= SPC_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      bresp_r <= (awaddr_r == SPC_OFS_CTRL || awaddr_r == SPC_OFS_STAT) ?
                 SPC_RESP_OKAY : SPC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ********************************************************************
  // Control word
  // ********************************************************************
  always_comb begin
    ctrl_nxt = ctrl_r;
    for (int i = 0; i < 4; i++) begin
      if (wstrb_r[i]) begin
        ctrl_nxt[i*8 +: 8] = wdata_r[i*8 +: 8];
      end
    end
    // Reserved bits are dropped so that a careless write cannot reach the classifier.
    ctrl_nxt = ctrl_nxt & SPC_CTRL_MASK;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= SPC_CTRL_RST;
    end else if (do_wr && awaddr_r == SPC_OFS_CTRL) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ********************************************************************
  // Read channel
  // ********************************************************************
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= SPC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r <= SPC_RESP_OKAY;
      case (s_axi_araddr)
        SPC_OFS_CTRL: rdata_r <= ctrl_r;
        SPC_OFS_STAT: rdata_r <= {26'h0, stat_r};
        default: begin
          rdata_r <= '0;
          rresp_r <= SPC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ********************************************************************
  // Classifier
  // ********************************************************************
  spc_cls_if cls_if ();

  assign cls_if.ctrl = ctrl_r;
  assign cls_if.hdr_valid = hdr_valid;
  assign cls_if.eth_type = hdr_eth_type;
  assign cls_if.ip_proto = hdr_ip_proto;
  assign cls_if.ip_dst = hdr_ip_dst;
  assign cls_if.ip6_next = hdr_ip6_next;
  assign cls_if.msg_type = hdr_msg_type;
  assign cls_if.udp_dport = hdr_udp_dport;

  spc_classifier u_cls (
    .clock(clock),
    .nrst(nrst),
    .ifc(cls_if.cls)
  );

  assign dec_valid = cls_if.res_valid;
  assign dec_class = cls_if.res_class;
  assign dec_cpu_copy = cls_if.res_copy;
  assign dec_cpu_only = cls_if.res_only;
  assign dec_l2_fwd = cls_if.res_l2;

  // Status keeps the last decision so software can see what the snooper did.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stat_r <= '0;
    end else if (cls_if.res_valid) begin
      stat_r <= {cls_if.res_only, cls_if.res_copy, cls_if.res_class};
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  a_jl_trap: assert property (@(posedge clock) disable iff (!nrst)
    (hdr_valid && hdr_eth_type == ETH_IPV4 && hdr_ip_proto == PROTO_IGMP &&
     !ctrl_r[BIT_IGMP_DIP] && hdr_msg_type == IGMP_LEAVE && ctrl_r[BIT_JL_ON] &&
     ctrl_r[BIT_JL_TRAP])
    |=> (dec_cpu_only && !dec_l2_fwd && !dec_cpu_copy))
    else $error("Join/leave frame not trapped to CPU only");

  a_jl_off: assert property (@(posedge clock) disable iff (!nrst)
    (hdr_valid && hdr_eth_type == ETH_IPV4 && hdr_ip_proto == PROTO_IGMP &&
     hdr_msg_type == IGMP_REP_V2 && !ctrl_r[BIT_JL_ON])
    |=> (!dec_cpu_only && !dec_cpu_copy && dec_l2_fwd))
    else $error("Join/leave frame handled while snooping is off");

  a_resv_zero: assert property (@(posedge clock) disable iff (!nrst)
    (ctrl_r & ~SPC_CTRL_MASK) == 32'h0000_0000)
    else $error("Reserved control bits were stored");

  a_icmp6_trap: assert property (@(posedge clock) disable iff (!nrst)
    (hdr_valid && hdr_eth_type == ETH_IPV6 && hdr_ip6_next == NEXT_ICMP6 &&
     hdr_msg_type == 8'h87 && ctrl_r[BIT_ICMP6_ON])
    |=> (dec_cpu_only == $past(ctrl_r[BIT_ICMP6_TRAP]) &&
         dec_cpu_copy == !$past(ctrl_r[BIT_ICMP6_TRAP])))
    else $error("ICMPv6 mode bit not honoured");

  a_icmp4_copy: assert property (@(posedge clock) disable iff (!nrst)
    (hdr_valid && hdr_eth_type == ETH_IPV4 && hdr_ip_proto == PROTO_ICMP4)
    |=> (dec_l2_fwd && !dec_cpu_only && dec_cpu_copy == $past(ctrl_r[BIT_ICMP4])))
    else $error("ICMPv4 copy does not follow its bit");

  a_dhcp_copy: assert property (@(posedge clock) disable iff (!nrst)
    (hdr_valid && hdr_eth_type == ETH_IPV4 && hdr_ip_proto == PROTO_UDP &&
     hdr_udp_dport == PORT_DHCP_SRV)
    |=> (dec_l2_fwd && dec_cpu_copy == $past(ctrl_r[BIT_DHCP])))
    else $error("DHCP copy does not follow its bit");

  a_rev_copy: assert property (@(posedge clock) disable iff (!nrst)
    (hdr_valid && hdr_eth_type == ETH_REV_ADDR_RES)
    |=> (dec_l2_fwd && dec_cpu_copy == $past(ctrl_r[BIT_REV_ADDR_RES])))
    else $error("Reverse address frame copy wrong");

  a_addr_copy: assert property (@(posedge clock) disable iff (!nrst)
    (hdr_valid && hdr_eth_type == ETH_ADDR_RES)
    |=> (dec_l2_fwd && !dec_cpu_only && dec_cpu_copy == $past(ctrl_r[BIT_ADDR_RES])))
    else $error("Address frame copy wrong");

  a_lq_mode: assert property (@(posedge clock) disable iff (!nrst)
    (hdr_valid && hdr_eth_type == ETH_IPV6 && hdr_ip6_next == NEXT_ICMP6 &&
     hdr_msg_type == LSN_QUERY)
    |=> (dec_class == CLS_LSN_QRY &&
         dec_cpu_only == ($past(ctrl_r[BIT_LQ_ON]) && $past(ctrl_r[BIT_LQ_TRAP]))))
    else $error("Listener query handling wrong");

  a_lr_mode: assert property (@(posedge clock) disable iff (!nrst)
    (hdr_valid && hdr_eth_type == ETH_IPV6 && hdr_ip6_next == NEXT_ICMP6 &&
     hdr_msg_type == LSN_DONE && ctrl_r[BIT_LR_ON] && !ctrl_r[BIT_LR_TRAP])
    |=> (dec_cpu_copy && dec_l2_fwd))
    else $error("Listener done not copied");

  a_igu_mode: assert property (@(posedge clock) disable iff (!nrst)
    (hdr_valid && hdr_eth_type == ETH_IPV4 && hdr_ip_proto == PROTO_IGMP &&
     !ctrl_r[BIT_IGMP_DIP] && hdr_msg_type == 8'h30 && ctrl_r[BIT_IGU_ON] &&
     ctrl_r[BIT_IGU_TRAP])
    |=> (dec_class == CLS_IGMP_UKN && dec_cpu_only))
    else $error("Unknown IGMP not trapped");

  a_igq_mode: assert property (@(posedge clock) disable iff (!nrst)
    (hdr_valid && hdr_eth_type == ETH_IPV4 && hdr_ip_proto == PROTO_IGMP &&
     !ctrl_r[BIT_IGMP_DIP] && hdr_msg_type == IGMP_QUERY && ctrl_r[BIT_IGQ_ON] &&
     !ctrl_r[BIT_IGQ_TRAP])
    |=> (dec_class == CLS_IGMP_QRY && dec_cpu_copy && dec_l2_fwd))
    else $error("IGMP query not copied");

  a_mode_ignored: assert property (@(posedge clock) disable iff (!nrst)
    (hdr_valid && !ctrl_r[BIT_ICMP6_ON] && !ctrl_r[BIT_JL_ON] && !ctrl_r[BIT_IGQ_ON] &&
     !ctrl_r[BIT_IGU_ON] && !ctrl_r[BIT_LR_ON] && !ctrl_r[BIT_LQ_ON] &&
     (hdr_eth_type == ETH_IPV6 || (hdr_eth_type == ETH_IPV4 && hdr_ip_proto == PROTO_IGMP)))
    |=> (dec_l2_fwd && !dec_cpu_only && !dec_cpu_copy))
    else $error("Mode bit acted while snooping was off");

  a_write_resp: assert property (@(posedge clock) disable iff (!nrst)
    do_wr |=> (s_axi_bvalid && ctrl_r == (($past(awaddr_r) == SPC_OFS_CTRL) ?
              $past(ctrl_nxt) : $past(ctrl_r))))
    else $error("Write response or update missing");

endmodule // spc_top

`default_nettype wire

// ---- verif/spc_hdr_src.sv ----
// Purpose: Forwarding-engine model that hands parsed headers to the classifier.
// Assumes: One header per call, a one-cycle valid pulse launched after a rising edge.
// Notes: Between headers the fields carry the inverse of the last value, never a held copy.
`timescale 1ns/1ns
`default_nettype none

module spc_hdr_src (
  input wire logic clock,
  output logic hdr_valid,
  output logic [15:0] hdr_eth_type,
  output logic [7:0] hdr_ip_proto,
  output logic [31:0] hdr_ip_dst,
  output logic [7:0] hdr_ip6_next,
  output logic [7:0] hdr_msg_type,
  output logic [15:0] hdr_udp_dport
);
  initial begin
    {hdr_valid, hdr_eth_type, hdr_ip_proto, hdr_ip_dst} = '0;
    {hdr_ip6_next, hdr_msg_type, hdr_udp_dport} = '0;
  end

  // Stale fields are scrambled so that a classifier sampling outside the pulse gets caught.
  task automatic send(input logic [15:0] e, input logic [7:0] p, input logic [31:0] d,
      input logic [7:0] n, input logic [7:0] m, input logic [15:0] u);
    @(posedge clock);
    hdr_valid <= 1'b1;
    {hdr_eth_type, hdr_ip_proto, hdr_ip_dst, hdr_ip6_next, hdr_msg_type, hdr_udp_dport}
      <= {e, p, d, n, m, u};
    @(posedge clock);
    hdr_valid <= 1'b0;
    {hdr_eth_type, hdr_ip_proto, hdr_ip_dst, hdr_ip6_next, hdr_msg_type, hdr_udp_dport}
      <= ~{e, p, d, n, m, u};
  endtask
endmodule // spc_hdr_src

`default_nettype wire

// ---- verif/testbench.sv ----
// Purpose: Self-checking bench for the protocol snoop classifier.
// Assumes: AXI4-Lite master tasks here, header source model beside the design.
// Notes: The class field is compared only where a CPU action is expected.
`timescale 1ns/1ns
`default_nettype none

module testbench;
  import spc_pkg::*;
  logic clock, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [SPC_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, hdr_ip_dst, rd;
  logic [3:0] s_axi_wstrb, dec_class;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic hdr_valid, dec_valid, dec_cpu_copy, dec_cpu_only, dec_l2_fwd;
  logic [15:0] hdr_eth_type, hdr_udp_dport;
  logic [7:0] hdr_ip_proto, hdr_ip6_next, hdr_msg_type;
  int error_cnt = 0;
  int n_compared = 0;

  spc_top spc_top_i (.*);
  spc_hdr_src spc_hdr_src_i (.*);

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clock);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    forever begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    forever begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        {rd, rsp} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  // Expected x is {cpu only, cpu copy, class}, the same layout as the status word.
  task automatic run_case(input logic [31:0] c, input logic [15:0] e, input logic [5:0] x,
      input logic [7:0] p = 8'h00, input logic [31:0] d = 32'h0, input logic [7:0] m = 8'h00,
      input logic [7:0] nh = 8'h00, input logic [15:0] u = 16'h0);
    logic [31:0] mk;
    mk = (x[5:4] != 2'h0) ? 32'h3F : 32'h30;
    axi_wr(SPC_OFS_CTRL, c, 4'hF);
    chk({30'h0, rsp}, {30'h0, SPC_RESP_OKAY});
    spc_hdr_src_i.send(e, p, d, nh, m, u);
    #1;
    chk({31'h0, dec_valid}, 32'h1);
    chk({31'h0, dec_l2_fwd}, {31'h0, ~x[5]});
    chk({26'h0, dec_cpu_only, dec_cpu_copy, dec_class} & mk, {26'h0, x} & mk);
    axi_rd(SPC_OFS_STAT);
    chk(rd & mk, {26'h0, x} & mk);
    chk({30'h0, rsp}, {30'h0, SPC_RESP_OKAY});
  endtask

  // ******************
  // Tests
  // ******************
  initial begin
    nrst = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    axi_rd(SPC_OFS_CTRL);
    chk(rd, SPC_CTRL_RST);
    axi_wr(SPC_OFS_CTRL, 32'hFFFF_FF3F, 4'h1);
    axi_rd(SPC_OFS_CTRL);
    chk(rd, 32'h3F);
    axi_wr(SPC_OFS_CTRL, 32'hFFFF_FF3F, 4'hF);
    axi_rd(SPC_OFS_CTRL);
    chk(rd, SPC_CTRL_MASK);
    axi_wr(SPC_OFS_STAT, 32'h0, 4'hF);
    chk({30'h0, rsp}, {30'h0, SPC_RESP_OKAY});
    axi_rd(SPC_OFS_CTRL);
    chk(rd, SPC_CTRL_MASK);
    axi_wr(8'h60, 32'h0, 4'hF);
    chk({30'h0, rsp}, {30'h0, SPC_RESP_SLVERR});
    axi_rd(8'h60);
    chk({rd[29:0], rsp}, {30'h0, SPC_RESP_SLVERR});
    run_case(32'h0, ETH_ADDR_RES, 6'h00);
    run_case(32'h1, ETH_ADDR_RES, 6'h11);
    run_case(32'h2, ETH_REV_ADDR_RES, 6'h12);
    run_case(32'h4, ETH_IPV4, 6'h13, PROTO_UDP, 32'h0, 8'h00, 8'h00, PORT_DHCP_CLI);
    run_case(32'h8, ETH_IPV4, 6'h14, PROTO_ICMP4);
    run_case(32'h10, ETH_IPV6, 6'h15, 8'h00, 32'h0, 8'h80, NEXT_ICMP6);
    run_case(32'h30, ETH_IPV6, 6'h25, 8'h00, 32'h0, 8'h87, NEXT_ICMP6);
    run_case(32'h30, ETH_IPV6, 6'h00, 8'h00, 32'h0, LSN_QUERY, NEXT_ICMP6);
    run_case(32'h20, ETH_IPV6, 6'h00, 8'h00, 32'h0, 8'h80, NEXT_ICMP6);
    run_case(32'h200, ETH_IPV4, 6'h16, PROTO_IGMP, 32'hE000_0001, IGMP_REP_V2);
    run_case(32'h600, ETH_IPV4, 6'h26, PROTO_IGMP, 32'h0A00_0001, IGMP_LEAVE);
    run_case(32'h400, ETH_IPV4, 6'h00, PROTO_IGMP, 32'hE000_0001, IGMP_REP_V1);
    run_case(32'h700, ETH_IPV4, 6'h00, PROTO_IGMP, 32'hF000_0000, IGMP_REP_V3);
    run_case(32'h700, ETH_IPV4, 6'h26, PROTO_IGMP, 32'hEFFF_FFFF, IGMP_REP_V3);
    run_case(32'h1800, ETH_IPV4, 6'h27, PROTO_IGMP, 32'hE000_0001, IGMP_QUERY);
    run_case(32'h800, ETH_IPV4, 6'h17, PROTO_IGMP, 32'hE000_0001, IGMP_QUERY);
    run_case(32'h2000, ETH_IPV4, 6'h18, PROTO_IGMP, 32'hE000_0001, 8'h25);
    run_case(32'h6000, ETH_IPV4, 6'h28, PROTO_IGMP, 32'hE000_0001, 8'h25);
    run_case(32'h18000, ETH_IPV6, 6'h2A, 8'h00, 32'h0, LSN_REP_V1, NEXT_ICMP6);
    run_case(32'h8000, ETH_IPV6, 6'h1A, 8'h00, 32'h0, LSN_DONE, NEXT_ICMP6);
    run_case(32'h20000, ETH_IPV6, 6'h19, 8'h00, 32'h0, LSN_QUERY, NEXT_ICMP6);
    run_case(32'h60000, ETH_IPV6, 6'h29, 8'h00, 32'h0, LSN_QUERY, NEXT_ICMP6);
    run_case(32'h40000, ETH_IPV6, 6'h00, 8'h00, 32'h0, LSN_QUERY, NEXT_ICMP6);
    finish_test();
  end

  // The tests need well under a thousand cycles; this allows twenty thousand.
  initial begin
    #2_000_000;
    error_cnt++;
    finish_test();
  end
endmodule // testbench

`default_nettype wire
